// file: core/pbu_params.svh
// Register map, field positions and reset values of the program break unit.
`ifndef PBU_PARAMS_SVH
`define PBU_PARAMS_SVH
`define PBU_OFS_ADDR_FIRST 8'h00
`define PBU_OFS_ADDR_SECOND 8'h04
`define PBU_OFS_CTRL_FIRST 8'h08
`define PBU_OFS_CTRL_SECOND 8'h0C
`define PBU_OFS_STOP 8'h10
`define PBU_BIT_FLAG 7
`define PBU_BIT_MASTER 6
`define PBU_BIT_MASK_HI 5
`define PBU_BIT_MASK_LO 3
`define PBU_BIT_COND_HI 2
`define PBU_BIT_COND_LO 1
`define PBU_BIT_IE 0
`define PBU_RST_ADDR 24'h000000
`define PBU_RST_CTRL 8'h00
`define PBU_RST_STOP 1'b1
`endif

// file: core/pbu_pkg.sv
// Types shared by the program break unit.
`default_nettype none
package pbu_pkg;
    typedef enum logic [1:0] {
        PBU_COND_FETCH = 2'b00,
        PBU_COND_READ = 2'b01,
        PBU_COND_WRITE = 2'b10,
        PBU_COND_RW = 2'b11
    } pbu_cond_e;
    typedef logic [23:0] pbu_addr_t;
    typedef logic [2:0] pbu_mask_t;
endpackage
`default_nettype wire

// file: core/pbu_top.sv
// Two-channel program break unit with a classic Wishbone register slave.
`default_nettype none
`include "pbu_params.svh"
// What this block does
// - Mask code hides 0-4, 8, 12, 16 low bits.
// - Condition selects fetch, read, write or either.
// - Request passes only while enable bit is set.
// - Second control register mirrors the first.
// - Fetch match flags and requests before execution.
// - Data match flags after the instruction completes.
// - Stack and branch reads count as data.
// - Request goes to interrupt controller, not exception.
// - Block move defers request until it ends.
// - Transfer controller match waits for its end.
// - Fetch break after sleep skips sleep entry.
// - Standby entry skips handling but sets flag.
// - Enable adds a state to on-chip branches.
// - Data access to fetch-break address adds state.
// - Memory-mode predecessor of break adds a state.
// - Simple predecessor of break adds a state.
// - Unit starts stopped; registers dead until cleared.
// - Both channels share one request line.
// - Flags clear by zero write after read.
// - Transfer-controller-owned bus delays request acceptance.
// - Master select picks processor or both masters.
// - Each channel holds 24-bit address, reset zero.
module pbu_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic bus_valid_in,
    input wire pbu_pkg::pbu_addr_t bus_addr_in,
    input wire logic bus_fetch_in,
    input wire logic bus_write_in,
    input wire logic bus_tc_in,
    input wire logic bus_onchip_in,
    input wire logic insn_exec_in,
    input wire logic insn_flush_in,
    input wire logic insn_done_in,
    input wire logic block_move_busy_in,
    input wire logic tc_owns_bus_in,
    input wire logic tc_xfer_end_in,
    input wire logic sleep_req_in,
    input wire logic standby_sel_in,
    input wire logic branch_onchip_in,
    input wire logic prev_mem_onchip_in,
    input wire logic prev_simple_onchip_in,
    output logic break_req_out,
    output logic sleep_skip_out,
    output logic extra_state_out,
    output logic [1:0] match_flag_out
);
    import pbu_pkg::*;

    pbu_addr_t bar_ff [2];
    logic [1:0] flag_ff;
    logic [1:0] master_ff;
    pbu_mask_t mask_ff [2];
    pbu_cond_e cond_ff [2];
    logic [1:0] ie_ff;
    logic [1:0] armed_ff;
    logic [1:0] pend_fetch_ff;
    logic [1:0] pend_data_ff;
    logic [1:0] tc_hold_ff;
    logic stop_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic req_ff;
    logic skip_ff;
    logic extra_ff;

    logic [1:0] fmatch;
    logic [1:0] dmatch;
    logic [1:0] ffmatch;
    logic [1:0] rel_fetch;
    logic [1:0] rel_data;
    logic [1:0] clr_flag;
    logic [1:0] nxt_flag;
    logic [1:0] wr_ctrl;
    logic [1:0] wr_addr;
    logic req_take;
    logic wr_take;
    logic [31:0] nxt_rdat;
    logic [ADDR_W-1:0] ofs_addr [2];
    logic [ADDR_W-1:0] ofs_ctrl [2];

    assign ofs_addr[0] = ADDR_W'(`PBU_OFS_ADDR_FIRST);
    assign ofs_addr[1] = ADDR_W'(`PBU_OFS_ADDR_SECOND);
    assign ofs_ctrl[0] = ADDR_W'(`PBU_OFS_CTRL_FIRST);
    assign ofs_ctrl[1] = ADDR_W'(`PBU_OFS_CTRL_SECOND);

    // Low-bit mask for a mask code; ones mark the bits that are compared.
    function automatic pbu_addr_t cmp_mask(input pbu_mask_t code);
        pbu_addr_t m;
        m = 24'hFFFFFF;
        unique case (code)
            3'h0: m = 24'hFFFFFF;
            3'h1: m = 24'hFFFFFE;
            3'h2: m = 24'hFFFFFC;
            3'h3: m = 24'hFFFFF8;
            3'h4: m = 24'hFFFFF0;
            3'h5: m = 24'hFFFF00;
            3'h6: m = 24'hFFF000;
            3'h7: m = 24'hFF0000;
        endcase
        return m;
    endfunction

    // Wishbone answers one cycle after the strobe and drops ack the next cycle.
    assign req_take = wb_cyc_in && wb_stb_in && !ack_ff;
    assign wr_take = wb_cyc_in && wb_stb_in && wb_we_in && ack_ff && !stop_ff;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_ff <= 1'b0;
        end else if (ce_in) begin
            ack_ff <= req_take;
        end
    end

    always_comb begin
        nxt_rdat = 32'h00000000;
        if (wb_adr_in == ADDR_W'(`PBU_OFS_STOP)) begin
            nxt_rdat = {31'h00000000, stop_ff};
        end else if (!stop_ff) begin
            for (int c = 0; c < 2; c++) begin
                if (wb_adr_in == ofs_addr[c]) begin
                    nxt_rdat = {8'h00, bar_ff[c]};
                end
                if (wb_adr_in == ofs_ctrl[c]) begin
                    nxt_rdat = {24'h000000, flag_ff[c], master_ff[c], mask_ff[c],
                        cond_ff[c], ie_ff[c]};
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdat_ff <= 32'h00000000;
        end else if (ce_in && req_take) begin
            rdat_ff <= wb_we_in ? 32'h00000000 : nxt_rdat;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stop_ff <= `PBU_RST_STOP;
        end else if (ce_in && wb_cyc_in && wb_stb_in && wb_we_in && ack_ff &&
                wb_adr_in == ADDR_W'(`PBU_OFS_STOP) && wb_sel_in[0]) begin
            stop_ff <= wb_dat_in[0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            // Channel comparison; the second channel is an exact copy of the first.
            logic addr_eq;
            logic master_ok;
            assign addr_eq = ((bus_addr_in ^ bar_ff[g]) & cmp_mask(mask_ff[g])) == 24'h000000;
            assign master_ok = !bus_tc_in || master_ff[g];
            assign fmatch[g] = bus_valid_in && !stop_ff && addr_eq && bus_fetch_in &&
                !bus_tc_in && cond_ff[g] == PBU_COND_FETCH;
            // Stack and branch-target reads arrive as ordinary data reads.
            assign dmatch[g] = bus_valid_in && !stop_ff && addr_eq && !bus_fetch_in &&
                master_ok && ((bus_write_in && cond_ff[g][1]) ||
                (!bus_write_in && cond_ff[g][0]));
            assign ffmatch[g] = bus_valid_in && !stop_ff && addr_eq && !bus_fetch_in &&
                cond_ff[g] == PBU_COND_FETCH;
            assign rel_fetch[g] = (pend_fetch_ff[g] || fmatch[g]) &&
                (insn_exec_in || (sleep_req_in && standby_sel_in));
            assign rel_data[g] = (pend_data_ff[g] || dmatch[g]) && insn_done_in;
            assign wr_ctrl[g] = wr_take && wb_adr_in == ofs_ctrl[g] && wb_sel_in[0];
            assign wr_addr[g] = wr_take && wb_adr_in == ofs_addr[g];
            assign clr_flag[g] = wr_ctrl[g] && armed_ff[g] && !wb_dat_in[`PBU_BIT_FLAG];
            assign nxt_flag[g] = rel_fetch[g] || rel_data[g] || (flag_ff[g] && !clr_flag[g]);

            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    bar_ff[g] <= `PBU_RST_ADDR;
                end else if (ce_in && wr_addr[g]) begin
                    for (int b = 0; b < 3; b++) begin
                        if (wb_sel_in[b]) begin
                            bar_ff[g][8*b+:8] <= wb_dat_in[8*b+:8];
                        end
                    end
                end
            end

            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    master_ff[g] <= 1'(`PBU_RST_CTRL >> `PBU_BIT_MASTER);
                    mask_ff[g] <= 3'h0;
                    cond_ff[g] <= PBU_COND_FETCH;
                    ie_ff[g] <= 1'b0;
                end else if (ce_in && wr_ctrl[g]) begin
                    master_ff[g] <= wb_dat_in[`PBU_BIT_MASTER];
                    mask_ff[g] <= wb_dat_in[`PBU_BIT_MASK_HI:`PBU_BIT_MASK_LO];
                    cond_ff[g] <= pbu_cond_e'(wb_dat_in[`PBU_BIT_COND_HI:`PBU_BIT_COND_LO]);
                    ie_ff[g] <= wb_dat_in[`PBU_BIT_IE];
                end
            end

            // A new match wins over a clearing write in the same cycle.
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    flag_ff[g] <= 1'b0;
                    armed_ff[g] <= 1'b0;
                end else if (ce_in) begin
                    flag_ff[g] <= nxt_flag[g];
                    if (wr_ctrl[g]) begin
                        armed_ff[g] <= 1'b0;
                    end else if (req_take && !wb_we_in && !stop_ff &&
                            wb_adr_in == ofs_ctrl[g] && flag_ff[g]) begin
                        armed_ff[g] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    pend_fetch_ff[g] <= 1'b0;
                    pend_data_ff[g] <= 1'b0;
                    tc_hold_ff[g] <= 1'b0;
                end else if (ce_in) begin
                    if (rel_fetch[g] || insn_flush_in) begin
                        pend_fetch_ff[g] <= 1'b0;
                    end else if (fmatch[g]) begin
                        pend_fetch_ff[g] <= 1'b1;
                    end
                    if (rel_data[g]) begin
                        pend_data_ff[g] <= 1'b0;
                    end else if (dmatch[g]) begin
                        pend_data_ff[g] <= 1'b1;
                    end
                    if (dmatch[g] && bus_tc_in) begin
                        tc_hold_ff[g] <= 1'b1;
                    end else if (tc_xfer_end_in) begin
                        tc_hold_ff[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // The shared request goes to the interrupt controller for priority resolution.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_ff <= 1'b0;
            skip_ff <= 1'b0;
            extra_ff <= 1'b0;
        end else if (ce_in) begin
            req_ff <= |(flag_ff & ie_ff & ~tc_hold_ff) && !block_move_busy_in &&
                !tc_owns_bus_in && !standby_sel_in;
            skip_ff <= sleep_req_in && !standby_sel_in && |(pend_fetch_ff & ie_ff);
            extra_ff <= (|ie_ff && branch_onchip_in) ||
                (|ffmatch && bus_onchip_in) ||
                (|(rel_fetch & ie_ff) && (prev_mem_onchip_in || prev_simple_onchip_in));
        end
    end

    assign wb_ack_out = ack_ff;
    assign wb_dat_out = rdat_ff;
    assign break_req_out = req_ff;
    assign sleep_skip_out = skip_ff;
    assign extra_state_out = extra_ff;
    assign match_flag_out = flag_ff;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held for two cycles");
    stop_read_a: assert property ($past(ce_in) && wb_ack_out && $past(stop_ff) &&
            $past(wb_adr_in) != ADDR_W'(`PBU_OFS_STOP) |-> wb_dat_out == 32'h00000000)
        else $error("register visible while stopped");
    flag_clear_a: assert property ($past(ce_in) && $fell(flag_ff[0]) |->
            $past(clr_flag[0]))
        else $error("flag cleared without a zero write after read");
    fetch_flag_a: assert property (ce_in && pend_fetch_ff[0] && insn_exec_in |=>
            flag_ff[0])
        else $error("fetch match did not set flag");
    data_flag_a: assert property (ce_in && (dmatch[0] || pend_data_ff[0]) &&
            insn_done_in |=> flag_ff[0])
        else $error("data match did not set flag");
    req_enable_a: assert property (break_req_out |-> $past(|(flag_ff & ie_ff)))
        else $error("request without enabled flag");
    block_move_a: assert property ($past(ce_in) && $past(block_move_busy_in) |->
            !break_req_out)
        else $error("request during block move");
    tc_owner_a: assert property ($past(ce_in) && $past(tc_owns_bus_in) |->
            !break_req_out)
        else $error("request while transfer controller owns bus");
    tc_hold_a: assert property (ce_in && dmatch[0] && bus_tc_in && !tc_xfer_end_in ##1
            ce_in && !tc_xfer_end_in |=> !(flag_ff[0] && req_ff && !flag_ff[1]))
        else $error("transfer controller match not held");
    branch_state_a: assert property (ce_in && ie_ff[0] && branch_onchip_in |=>
            extra_state_out)
        else $error("missing extra state on branch");
    // Timing side effects, power-down handling, flag hold, master select and the shared request.
    mem_extra_a: assert property (ce_in && |(rel_fetch & ie_ff) &&
            (prev_mem_onchip_in || prev_simple_onchip_in) |=> extra_state_out)
        else $error("missing extra state before break");
    data_extra_a: assert property (ce_in && |ffmatch && bus_onchip_in |=>
            extra_state_out)
        else $error("missing extra state on data access");
    sleep_skip_a: assert property (ce_in && sleep_req_in && !standby_sel_in &&
            |(pend_fetch_ff & ie_ff) |=> sleep_skip_out)
        else $error("sleep entry not skipped");
    standby_flag_a: assert property (ce_in && pend_fetch_ff[0] && sleep_req_in &&
            standby_sel_in |=> flag_ff[0] && !break_req_out)
        else $error("standby entry did not set flag quietly");
    flag_hold_a: assert property (ce_in && flag_ff[1] && !clr_flag[1] |=>
            flag_ff[1])
        else $error("flag cleared by itself");
    master_cpu_a: assert property (!master_ff[0] && bus_tc_in |-> !dmatch[0])
        else $error("transfer controller cycle matched processor-only channel");
    shared_req_a: assert property (ce_in && flag_ff[0] && ie_ff[0] && !tc_hold_ff[0] &&
            !block_move_busy_in && !tc_owns_bus_in && !standby_sel_in |=> break_req_out)
        else $error("shared request not raised");

    req_seen_c: cover property (flag_ff[0] && ie_ff[0] ##1 break_req_out);
    clear_seen_c: cover property (armed_ff[1] ##1 !flag_ff[1]);
    skip_seen_c: cover property (sleep_skip_out);
    both_flags_c: cover property (flag_ff == 2'b11);
    extra_seen_c: cover property (extra_state_out ##1 !extra_state_out);
endmodule // pbu_top
`default_nettype wire

// file: tb/pbu_cpu_model.sv
// Processor side model: drives internal bus cycles and instruction events.
`default_nettype none
module pbu_cpu_model (
    input wire logic clk_in,
    output logic valid_out,
    output pbu_pkg::pbu_addr_t addr_out,
    output logic fetch_out,
    output logic write_out,
    output logic tc_out,
    output logic onchip_out,
    output logic exec_out,
    output logic done_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import pbu_pkg::*;
    initial begin
        valid_out = 1'b0;
        addr_out = 24'h000000;
        fetch_out = 1'b0;
        write_out = 1'b0;
        tc_out = 1'b0;
        onchip_out = 1'b0;
        exec_out = 1'b0;
        done_out = 1'b0;
    end
    // One bus cycle; the address shows its inverse once the cycle is over.
    task automatic cycle(input pbu_addr_t a, input logic f, input logic w, input logic t);
        @(posedge clk_in);
        valid_out <= 1'b1;
        addr_out <= a;
        fetch_out <= f;
        write_out <= w;
        tc_out <= f ? 1'b0 : t;
        onchip_out <= 1'b1;
        @(posedge clk_in);
        valid_out <= 1'b0;
        addr_out <= ~a;
        onchip_out <= 1'b0;
    endtask
    // Pulses instruction completion when d is set, else instruction execution.
    task automatic pulse(input logic d);
        @(posedge clk_in);
        done_out <= d;
        exec_out <= ~d;
        @(posedge clk_in);
        done_out <= 1'b0;
        exec_out <= 1'b0;
    endtask
endmodule // pbu_cpu_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the program break unit.
`default_nettype none
`include "pbu_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pbu_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic bmb = 1'b0;
    logic tco = 1'b0;
    logic tce = 1'b0;
    logic slp = 1'b0;
    logic sby = 1'b0;
    logic brn = 1'b0;
    logic flush = 1'b0;
    logic pmem = 1'b0;
    logic psim = 1'b0;
    logic [31:0] rdat;
    logic ack, req, skip, extra, bv, bf, bw, bt, bo, ex, dn;
    logic [1:0] flag;
    pbu_addr_t ba;
    logic [31:0] st;
    logic [31:0] xs;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    assign st = {29'h0, req, flag};
    assign xs = {30'h0, extra, skip};
    always #2.5 clk_in = ~clk_in;
    pbu_cpu_model u_cpu (.clk_in(clk_in), .valid_out(bv), .addr_out(ba), .fetch_out(bf),
        .write_out(bw), .tc_out(bt), .onchip_out(bo), .exec_out(ex), .done_out(dn));
    pbu_top u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .bus_valid_in(bv), .bus_addr_in(ba),
        .bus_fetch_in(bf), .bus_write_in(bw), .bus_tc_in(bt), .bus_onchip_in(bo),
        .insn_exec_in(ex), .insn_flush_in(flush), .insn_done_in(dn),
        .block_move_busy_in(bmb), .tc_owns_bus_in(tco), .tc_xfer_end_in(tce),
        .sleep_req_in(slp), .standby_sel_in(sby), .branch_onchip_in(brn),
        .prev_mem_onchip_in(pmem), .prev_simple_onchip_in(psim), .break_req_out(req),
        .sleep_skip_out(skip), .extra_state_out(extra), .match_flag_out(flag));
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Classic single Wishbone cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_in);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk_in);
        while (ack !== 1'b1)
            @(posedge clk_in);
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic t_reset;
        rdc(`PBU_OFS_STOP, 32'h1);
        wr(`PBU_OFS_ADDR_FIRST, 32'h00ABCDEF);
        rdc(`PBU_OFS_ADDR_FIRST, 32'h0);
        wr(`PBU_OFS_STOP, 32'h0);
        rdc(`PBU_OFS_ADDR_FIRST, 32'h0);
        rdc(`PBU_OFS_CTRL_SECOND, 32'h0);
        rdc(8'h20, 32'h0);
        wr(`PBU_OFS_ADDR_SECOND, 32'hFFFFFFFF);
        rdc(`PBU_OFS_ADDR_SECOND, 32'h00FFFFFF);
    endtask
    task automatic t_fetch;
        wr(`PBU_OFS_ADDR_FIRST, 32'h00002000);
        wr(`PBU_OFS_CTRL_FIRST, 32'h00);
        u_cpu.cycle(24'h002000, 1'b1, 1'b0, 1'b0);
        idle(3);
        chk(st, 32'h0);
        u_cpu.pulse(1'b0);
        idle(3);
        chk(st, 32'h1);
        wr(`PBU_OFS_CTRL_FIRST, 32'h01);
        idle(3);
        chk(st, 32'h5);
        rdc(`PBU_OFS_CTRL_FIRST, 32'h81);
        wr(`PBU_OFS_CTRL_FIRST, 32'h01);
        idle(3);
        chk(st, 32'h0);
        u_cpu.cycle(24'h002000, 1'b1, 1'b0, 1'b0);
        slp <= 1'b1;
        idle(3);
        chk(xs, 32'h1);
        slp <= 1'b0;
        brn <= 1'b1;
        idle(3);
        chk(xs, 32'h2);
        brn <= 1'b0;
        sby <= 1'b1;
        slp <= 1'b1;
        idle(3);
        chk(st, 32'h1);
        slp <= 1'b0;
        sby <= 1'b0;
        rdc(`PBU_OFS_CTRL_FIRST, 32'h81);
        wr(`PBU_OFS_CTRL_FIRST, 32'h0);
        for (int i = 0; i < 2; i++) begin
            pmem <= (i == 0);
            psim <= (i == 1);
            wr(`PBU_OFS_CTRL_FIRST, 32'h01);
            u_cpu.cycle(24'h002000, 1'b1, 1'b0, 1'b0);
            u_cpu.pulse(1'b0);
            idle(1);
            chk(xs, 32'h2);
            rdc(`PBU_OFS_CTRL_FIRST, 32'h81);
            wr(`PBU_OFS_CTRL_FIRST, 32'h0);
        end
        pmem <= 1'b0;
        psim <= 1'b0;
        wr(`PBU_OFS_CTRL_FIRST, 32'h01);
        u_cpu.cycle(24'h002000, 1'b1, 1'b0, 1'b0);
        flush <= 1'b1;
        idle(1);
        flush <= 1'b0;
        u_cpu.pulse(1'b0);
        idle(3);
        chk(st, 32'h0);
        u_cpu.cycle(24'h002000, 1'b0, 1'b0, 1'b0);
        idle(1);
        chk(xs, 32'h2);
        wr(`PBU_OFS_CTRL_FIRST, 32'h0);
    endtask
    task automatic t_mask;
        int b;
        wr(`PBU_OFS_ADDR_SECOND, 32'h00FF0000);
        for (int i = 0; i < 8; i++) begin
            b = (i < 5) ? i : 4 * i - 12;
            wr(`PBU_OFS_CTRL_SECOND, {26'h0, i[2:0], 3'b100});
            u_cpu.cycle(24'hFF0000 ^ (24'h1 << b), 1'b0, 1'b1, 1'b0);
            u_cpu.pulse(1'b1);
            idle(3);
            chk(st, 32'h0);
            u_cpu.cycle(24'hFF0000 | ((24'h1 << b) - 24'h1), 1'b0, 1'b1, 1'b0);
            u_cpu.pulse(1'b1);
            idle(3);
            chk(st, 32'h2);
            rdc(`PBU_OFS_CTRL_SECOND, {24'h0, 2'b10, i[2:0], 3'b100});
            wr(`PBU_OFS_CTRL_SECOND, 32'h0);
        end
    endtask
    task automatic t_cond;
        wr(`PBU_OFS_ADDR_FIRST, 32'h00001000);
        for (int c = 0; c < 4; c++) begin
            for (int w = 0; w < 2; w++) begin
                wr(`PBU_OFS_CTRL_FIRST, {29'h0, c[1:0], 1'b0});
                u_cpu.cycle(24'h001000, 1'b0, w[0], 1'b0);
                u_cpu.pulse(1'b1);
                idle(3);
                chk(st, {31'h0, c[w]});
                rdc(`PBU_OFS_CTRL_FIRST, {24'h0, c[w], 4'h0, c[1:0], 1'b0});
                wr(`PBU_OFS_CTRL_FIRST, 32'h0);
            end
        end
    endtask
    task automatic t_master;
        wr(`PBU_OFS_CTRL_FIRST, 32'h03);
        u_cpu.cycle(24'h001000, 1'b0, 1'b0, 1'b1);
        u_cpu.pulse(1'b1);
        idle(3);
        chk(st, 32'h0);
        wr(`PBU_OFS_CTRL_FIRST, 32'h43);
        tco <= 1'b1;
        u_cpu.cycle(24'h001000, 1'b0, 1'b0, 1'b1);
        u_cpu.pulse(1'b1);
        idle(3);
        chk(st, 32'h1);
        tce <= 1'b1;
        idle(1);
        tce <= 1'b0;
        idle(3);
        chk(st, 32'h1);
        tco <= 1'b0;
        idle(3);
        chk(st, 32'h5);
        bmb <= 1'b1;
        idle(3);
        chk(st, 32'h1);
        bmb <= 1'b0;
        idle(3);
        chk(st, 32'h5);
        rdc(`PBU_OFS_CTRL_FIRST, 32'hC3);
        wr(`PBU_OFS_CTRL_FIRST, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_fetch();
        t_mask();
        t_cond();
        t_master();
        stop_test();
    end
endmodule // tb
`default_nettype wire
